// ### dv/dcpi_mc_model.sv
// behavioural memory controller driving the command pins
`timescale 1ns/1ps
module dcpi_mc_model (
   // bench clock and link clock run control
   input wire logic clk,
   input wire logic clkRun,
   // pins towards the device
   output logic diffClockP,
   output logic diffClockN,
   output logic clockGateIn,
   output logic rankSelectN,
   output logic rowStrobeN,
   output logic columnStrobeN,
   output logic writeStrobeN,
   output logic [2:0] bankSelect,
   output logic [13:0] addr,
   output logic terminationEnable,
   output logic writeByteMask,
   output logic dataStrobe
);
   assign diffClockN = ~diffClockP;
   initial begin
      {clockGateIn, rankSelectN, rowStrobeN, columnStrobeN, writeStrobeN} = 5'h1f;
      {bankSelect, addr, terminationEnable, writeByteMask, dataStrobe} = 20'h00000;
      diffClockP = 1'b0;
      #7;
      forever #160 if (clkRun) diffClockP = ~diffClockP;
   end
   ////////////////////////////////////////////////////////////////////////////////
   // pins change on the first bench clock edge after a falling edge and stand across one rising crossing
   task automatic issue(input logic [2:0] c, input logic [2:0] b, input logic [13:0] a,
         input logic rk, input logic g);
      @(negedge diffClockP);
      @(posedge clk);
      rankSelectN <= rk;
      {rowStrobeN, columnStrobeN, writeStrobeN} <= c;
      bankSelect <= b;
      addr <= a;
      clockGateIn <= g;
      @(negedge diffClockP);
      @(posedge clk);
      rankSelectN <= 1'b1;
      {rowStrobeN, columnStrobeN, writeStrobeN} <= 3'h7;
      bankSelect <= ~b;
      addr <= ~a;
   endtask
   task automatic setLevels(input logic g, input logic t);
      @(posedge clk);
      clockGateIn <= g;
      terminationEnable <= t;
   endtask
   task automatic beats(input logic [7:0] m, input int n);
      for (int i = 0; i < n; i++) begin
         @(posedge clk);
         writeByteMask <= m[i];
         clockGateIn <= 1'b1;
         repeat (3) @(posedge clk);
         dataStrobe <= ~dataStrobe;
         repeat (3) @(posedge clk);
      end
   endtask
endmodule // dcpi_mc_model

// ### dv/dcpi_props.sv
// concurrent checks on the command pin decoder ports
`timescale 1ns/1ps
module dcpi_props #(
   parameter bit WIDE16 = 1'b0
) (
   // clock and reset
   input wire logic clk,
   input wire logic resetn,
   // observed outputs
   input dcpi_pkg::dcpiEvt_t cmdEvt,
   input wire logic beatDrop,
   input wire logic clockBufEn,
   input wire logic termBufEn,
   input wire logic inputBufEn,
   input wire logic termOn,
   input wire logic [1:0] termLanes,
   input wire logic maskIsStrobe,
   input dcpi_pkg::dcpiPwr_t pwrState
);
   logic anyCmd;
   logic lowPwr;
   assign anyCmd = cmdEvt.activate | cmdEvt.read | cmdEvt.write | cmdEvt.precharge
      | cmdEvt.modeLoad;
   assign lowPwr = (pwrState == dcpi_pkg::PWR_PPD) || (pwrState == dcpi_pkg::PWR_APD);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!resetn);
   ////////////////////////////////////////////////////////////////////////////////
   a_one_cmd:
      assert property ($onehot0({cmdEvt.activate, cmdEvt.read, cmdEvt.write,
         cmdEvt.precharge, cmdEvt.modeLoad})) else $error("two commands at once");
   a_cmd_pulse:
      assert property (anyCmd |=> !anyCmd) else $error("command pulse too long");
   a_pall_bit:
      assert property (cmdEvt.precharge |-> cmdEvt.prechargeAll == cmdEvt.addr[10])
         else $error("precharge all flag wrong");
   a_auto_pre:
      assert property ((cmdEvt.read || cmdEvt.write) |-> cmdEvt.autoPrecharge == cmdEvt.addr[10])
         else $error("auto precharge flag wrong");
   a_run_bufs:
      assert property (pwrState == dcpi_pkg::PWR_RUN |-> inputBufEn && clockBufEn && termBufEn)
         else $error("buffers off in run");
   a_pd_bufs:
      assert property (lowPwr |-> clockBufEn && termBufEn && !inputBufEn)
         else $error("power-down buffers wrong");
   a_sref_bufs:
      assert property (pwrState == dcpi_pkg::PWR_SREF |->
         !clockBufEn && !termBufEn && !inputBufEn && !termOn) else $error("self refresh buffers on");
   a_quiet_pd:
      assert property (pwrState != dcpi_pkg::PWR_RUN && $past(pwrState) != dcpi_pkg::PWR_RUN
         |-> !anyCmd) else $error("command decoded while powered down");
   a_mask_off:
      assert property (maskIsStrobe |-> !beatDrop) else $error("mask active in strobe mode");
   a_lane_map:
      assert property (termOn |-> termLanes == {WIDE16, 1'b1}) else $error("termination lanes wrong");
   c_sref: cover property (pwrState == dcpi_pkg::PWR_SREF);
   c_drop: cover property (beatDrop);
   c_pall: cover property (cmdEvt.precharge && cmdEvt.prechargeAll);
endmodule // dcpi_props

// ### dv/ddr2_command_pin_interface_tb.sv
// self-checking bench for the command pin decoder
`timescale 1ns/1ps
`include "dcpi_consts.svh"
module ddr2_command_pin_interface_tb;
   logic clk = 1'b0;
   logic resetn = 1'b0;
   logic clkRun = 1'b1;
   logic diffClockP, diffClockN, clockGateIn, rankSelectN, rowStrobeN, columnStrobeN;
   logic writeStrobeN, terminationEnable, writeByteMask, dataStrobe;
   logic [2:0] bankSelect;
   logic [13:0] addr;
   dcpi_pkg::dcpiEvt_t cmdEvt, lastEvt;
   dcpi_pkg::dcpiPwr_t pwrState;
   logic beatKeep, beatDrop, clockBufEn, termBufEn, inputBufEn, termOn, maskIsStrobe;
   logic [1:0] termLanes, bresp, rresp;
   logic [11:0] awaddr = 12'h000, araddr = 12'h000;
   logic [31:0] wdata = 32'h00000000, rdata;
   logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   logic awready, wready, bvalid, arready, rvalid;
   int numErrors = 0, checks = 0, evtCnt = 0, keepCnt = 0, dropCnt = 0, seed = 32'h7dc3f346;
   always #20 clk = ~clk;
   dcpi_top #(.WIDE16(1'b0)) dcpi_top_i (.clk(clk), .resetn(resetn), .diffClockP(diffClockP),
      .diffClockN(diffClockN), .clockGateIn(clockGateIn), .rankSelectN(rankSelectN),
      .rowStrobeN(rowStrobeN), .columnStrobeN(columnStrobeN), .writeStrobeN(writeStrobeN),
      .bankSelect(bankSelect), .addr(addr), .terminationEnable(terminationEnable),
      .writeByteMask(writeByteMask), .dataStrobe(dataStrobe), .cmdEvt(cmdEvt),
      .beatKeep(beatKeep), .beatDrop(beatDrop), .clockBufEn(clockBufEn), .termBufEn(termBufEn),
      .inputBufEn(inputBufEn), .termOn(termOn), .termLanes(termLanes),
      .maskIsStrobe(maskIsStrobe), .pwrState(pwrState), .s_axi_awaddr(awaddr),
      .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
      .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
      .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
      .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
      .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));
   dcpi_mc_model dcpi_mc_model_i (.clk(clk), .clkRun(clkRun), .diffClockP(diffClockP),
      .diffClockN(diffClockN), .clockGateIn(clockGateIn), .rankSelectN(rankSelectN),
      .rowStrobeN(rowStrobeN), .columnStrobeN(columnStrobeN), .writeStrobeN(writeStrobeN),
      .bankSelect(bankSelect), .addr(addr), .terminationEnable(terminationEnable),
      .writeByteMask(writeByteMask), .dataStrobe(dataStrobe));
   always @(posedge clk) begin
      if (cmdEvt.activate | cmdEvt.read | cmdEvt.write | cmdEvt.precharge | cmdEvt.modeLoad) begin
         evtCnt <= evtCnt + 1;
         lastEvt <= cmdEvt;
      end
      keepCnt <= keepCnt + int'(beatKeep);
      dropCnt <= dropCnt + int'(beatDrop);
   end
   ////////////////////////////////////////////////////////////////////////////////
   task automatic summarize;
      if (numErrors == 0 && checks > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         numErrors++;
         $display("unexpected t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic tmo;
      chk(32'h0, 32'h1);
      summarize();
   endtask
   task automatic settle;
      repeat (32) @(posedge clk);
   endtask
   function automatic logic [4:0] kind(input logic [2:0] c);
      case (c)
         `DCPI_CMD_ACTIVATE: return 5'h10;
         `DCPI_CMD_READ: return 5'h08;
         `DCPI_CMD_WRITE: return 5'h04;
         `DCPI_CMD_PRECHARGE: return 5'h02;
         `DCPI_CMD_MODE: return 5'h01;
         default: return 5'h00;
      endcase
   endfunction
   task automatic axiWr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
      logic ta, tw, tb;
      @(posedge clk);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      for (int n = 0; n < 40; n++) begin
         @(negedge clk);
         ta = awready;
         tw = wready;
         tb = bvalid;
         @(posedge clk);
         if (ta) awvalid <= 1'b0;
         if (tw) wvalid <= 1'b0;
         if (tb) begin
            bready <= 1'b0;
            chk(bresp, er);
            return;
         end
      end
      tmo();
   endtask
   task automatic rdChk(input logic [11:0] a, input logic [31:0] ed, input logic [1:0] er);
      logic ta, tr;
      @(posedge clk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      for (int n = 0; n < 40; n++) begin
         @(negedge clk);
         ta = arready;
         tr = rvalid;
         @(posedge clk);
         if (ta) arvalid <= 1'b0;
         if (tr) begin
            rready <= 1'b0;
            chk(rdata, ed);
            chk(rresp, er);
            return;
         end
      end
      tmo();
   endtask
   task automatic doCmd(input logic [2:0] c, input logic [2:0] b, input logic [13:0] a,
         input logic rk, input logic g, input int ex);
      int e0 = evtCnt;
      dcpi_mc_model_i.issue(c, b, a, rk, g);
      settle();
      chk(evtCnt - e0, ex);
      if (ex == 1) begin
         chk({lastEvt.activate, lastEvt.read, lastEvt.write, lastEvt.precharge, lastEvt.modeLoad},
            kind(c));
         chk({lastEvt.bank, lastEvt.addr}, {b, a});
         if (c == `DCPI_CMD_PRECHARGE) chk(lastEvt.prechargeAll, a[10]);
         if (c inside {`DCPI_CMD_READ, `DCPI_CMD_WRITE}) chk(lastEvt.autoPrecharge, a[10]);
      end
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      logic [13:0] a;
      logic [2:0] b;
      logic [7:0] m;
      int k0, d0;
      repeat (10) @(posedge clk);
      resetn <= 1'b1;
      @(posedge clk);
      chk(pwrState, dcpi_pkg::PWR_RUN);
      chk({inputBufEn, clockBufEn, termBufEn, termOn}, 4'he);
      rdChk(`DCPI_OFS_STATUS, 32'h1, `DCPI_RESP_OKAY);
      rdChk(`DCPI_OFS_CTRL, `DCPI_CTRL_RESET, `DCPI_RESP_OKAY);
      rdChk(12'h01c, 32'h0, `DCPI_RESP_SLVERR);
      axiWr(12'h020, 32'h1, `DCPI_RESP_SLVERR);
      for (int i = 0; i < 4; i++) begin
         a = 14'($random(seed));
         doCmd(`DCPI_CMD_MODE, 3'(i), a, 1'b0, 1'b1, 1);
         rdChk(`DCPI_OFS_MODE0 + 12'(4 * i), {18'h0, a}, `DCPI_RESP_OKAY);
      end
      for (int i = 0; i < 6; i++) begin
         b = 3'($random(seed));
         a = 14'($random(seed));
         doCmd(`DCPI_CMD_ACTIVATE, b, a, 1'b0, 1'b1, 1);
         doCmd(`DCPI_CMD_READ, b, ~a, 1'b0, 1'b1, 1);
         doCmd(`DCPI_CMD_PRECHARGE, b, a, 1'b0, 1'b1, 1);
      end
      doCmd(`DCPI_CMD_ACTIVATE, b, a, 1'b1, 1'b1, 0);
      axiWr(`DCPI_OFS_CTRL, 32'h0, `DCPI_RESP_OKAY);
      doCmd(`DCPI_CMD_ACTIVATE, b, a, 1'b0, 1'b1, 0);
      axiWr(`DCPI_OFS_CTRL, 32'h1, `DCPI_RESP_OKAY);
      doCmd(`DCPI_CMD_MODE, 3'h1, 14'h0004, 1'b0, 1'b1, 1);
      dcpi_mc_model_i.setLevels(1'b1, 1'b1);
      settle();
      chk({termOn, termLanes}, 3'h5);
      doCmd(`DCPI_CMD_MODE, 3'h1, 14'h0800, 1'b0, 1'b1, 1);
      chk({termOn, maskIsStrobe}, 2'h1);
      doCmd(`DCPI_CMD_MODE, 3'h1, 14'h0000, 1'b0, 1'b1, 1);
      doCmd(`DCPI_CMD_MODE, 3'h0, 14'(`DCPI_MR_BL8), 1'b0, 1'b1, 1);
      dcpi_mc_model_i.setLevels(1'b1, 1'b0);
      doCmd(`DCPI_CMD_WRITE, b, a, 1'b0, 1'b1, 1);
      m = 8'($random(seed));
      k0 = keepCnt;
      d0 = dropCnt;
      dcpi_mc_model_i.beats(m, 8);
      settle();
      chk(dropCnt - d0, $countones(m));
      chk(keepCnt - k0, 8 - $countones(m));
      rdChk(`DCPI_OFS_MASKED, $countones(m), `DCPI_RESP_OKAY);
      doCmd(`DCPI_CMD_PRECHARGE, 3'h0, 14'h0400, 1'b0, 1'b1, 1);
      doCmd(3'h7, 3'h0, 14'h0000, 1'b0, 1'b0, 0);
      chk(pwrState, dcpi_pkg::PWR_PPD);
      chk({inputBufEn, clockBufEn, termBufEn}, 3'h3);
      doCmd(`DCPI_CMD_ACTIVATE, b, a, 1'b0, 1'b0, 0);
      doCmd(3'h7, 3'h0, 14'h0000, 1'b0, 1'b1, 0);
      chk(pwrState, dcpi_pkg::PWR_RUN);
      doCmd(`DCPI_CMD_ACTIVATE, b, a, 1'b0, 1'b1, 1);
      doCmd(3'h7, 3'h0, 14'h0000, 1'b0, 1'b0, 0);
      chk(pwrState, dcpi_pkg::PWR_APD);
      doCmd(3'h7, 3'h0, 14'h0000, 1'b0, 1'b1, 0);
      doCmd(`DCPI_CMD_PRECHARGE, 3'h0, 14'h0400, 1'b0, 1'b1, 1);
      doCmd(`DCPI_CMD_REFRESH, 3'h0, 14'h0000, 1'b0, 1'b0, 0);
      chk(pwrState, dcpi_pkg::PWR_SREF);
      chk({inputBufEn, clockBufEn, termBufEn, termOn}, 4'h0);
      clkRun <= 1'b0;
      settle();
      dcpi_mc_model_i.setLevels(1'b1, 1'b0);
      settle();
      chk(pwrState, dcpi_pkg::PWR_RUN);
      clkRun <= 1'b1;
      summarize();
   end
   initial begin
      repeat (60000) @(posedge clk);
      tmo();
   end
endmodule // ddr2_command_pin_interface_tb
bind dcpi_top dcpi_props #(.WIDE16(WIDE16)) dcpi_props_i (.clk(clk), .resetn(resetn),
   .cmdEvt(cmdEvt), .beatDrop(beatDrop), .clockBufEn(clockBufEn), .termBufEn(termBufEn),
   .inputBufEn(inputBufEn), .termOn(termOn), .termLanes(termLanes),
   .maskIsStrobe(maskIsStrobe), .pwrState(pwrState));

// ### src/dcpi_consts.svh
// constants for the ddr2 command pin interface block
`ifndef DCPI_CONSTS_SVH
`define DCPI_CONSTS_SVH
// register byte offsets, control register reset value and decode enable bit
`define DCPI_OFS_STATUS 12'h000
`define DCPI_OFS_CTRL 12'h004
`define DCPI_OFS_MODE0 12'h008
`define DCPI_OFS_MODE1 12'h00c
`define DCPI_OFS_MODE2 12'h010
`define DCPI_OFS_MODE3 12'h014
`define DCPI_OFS_MASKED 12'h018
`define DCPI_CTRL_RESET 32'h00000001
`define DCPI_CTRL_DECODE_BIT 0
// command codes {row, column, write} strobes, active low
`define DCPI_CMD_MODE 3'h0
`define DCPI_CMD_REFRESH 3'h1
`define DCPI_CMD_PRECHARGE 3'h2
`define DCPI_CMD_ACTIVATE 3'h3
`define DCPI_CMD_WRITE 3'h4
`define DCPI_CMD_READ 3'h5
// mode register fields, precharge all bit, beat counts and response codes
`define DCPI_MR_BL_LSB 0
`define DCPI_MR_BL_MSB 2
`define DCPI_MR_BL8 3'h3
`define DCPI_EMR_RTT_LO 2
`define DCPI_EMR_RTT_HI 6
`define DCPI_EMR_READ_ONLY_STROBE 11
`define DCPI_PALL_BIT 10
`define DCPI_BEATS_BL4 4'h4
`define DCPI_BEATS_BL8 4'h8
`define DCPI_RESP_OKAY 2'h0
`define DCPI_RESP_SLVERR 2'h2
`endif

// ### src/dcpi_pkg.sv
// types for the ddr2 command pin interface block
package dcpi_pkg;
   typedef enum logic [3:0] {
      PWR_RUN = 4'h1,
      PWR_PPD = 4'h2,
      PWR_APD = 4'h4,
      PWR_SREF = 4'h8
   } dcpiPwr_t;
   // one registered sample of the command pins
   typedef struct packed {
      logic rankSelectN;
      logic rowStrobeN;
      logic columnStrobeN;
      logic writeStrobeN;
      logic terminationEnable;
      logic [2:0] bankSelect;
      logic [13:0] addr;
   } dcpiCmd_t;
   // decoded command pulses
   typedef struct packed {
      logic activate;
      logic read;
      logic write;
      logic precharge;
      logic prechargeAll;
      logic modeLoad;
      logic autoPrecharge;
      logic [2:0] bank;
      logic [13:0] addr;
   } dcpiEvt_t;
endpackage

// ### src/dcpi_top.sv
// ddr2 command pin decoder with power states and an axi4-lite register window
`timescale 1ns/1ps
`include "dcpi_consts.svh"
module dcpi_top #(
   parameter bit WIDE16 = 1'b0
) (
   // clock and reset
   input wire logic clk,
   input wire logic resetn,
   // memory pins from the controller
   input wire logic diffClockP,
   input wire logic diffClockN,
   input wire logic clockGateIn,
   input wire logic rankSelectN,
   input wire logic rowStrobeN,
   input wire logic columnStrobeN,
   input wire logic writeStrobeN,
   input wire logic [2:0] bankSelect,
   input wire logic [13:0] addr,
   input wire logic terminationEnable,
   input wire logic writeByteMask,
   input wire logic dataStrobe,
   // decoded commands towards the array
   output dcpi_pkg::dcpiEvt_t cmdEvt,
   output logic beatKeep,
   output logic beatDrop,
   // buffer, termination and mask pin control
   output logic clockBufEn,
   output logic termBufEn,
   output logic inputBufEn,
   output logic termOn,
   output logic [1:0] termLanes,
   output logic maskIsStrobe,
   output dcpi_pkg::dcpiPwr_t pwrState,
   // axi4-lite slave
   input wire logic [11:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [11:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready
);

   localparam int PW = 27;

   ////////////////////////////////////////////////////////////////////////////////
   // pin synchronisers
   logic [PW-1:0] pinRaw;
   logic [PW-1:0] pinMeta_q;
   logic [PW-1:0] pinSync_q;
   logic clkPPrev_q;
   logic clkNPrev_q;
   logic strobePrev_q;

   assign pinRaw = {diffClockP, diffClockN, clockGateIn, rankSelectN, rowStrobeN,
                    columnStrobeN, writeStrobeN, terminationEnable, bankSelect, addr,
                    writeByteMask, dataStrobe};

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         pinMeta_q <= '0;
         pinSync_q <= '0;
      end else begin
         pinMeta_q <= pinRaw;
         pinSync_q <= pinMeta_q;
      end
   end

   logic syncP;
   logic syncN;
   logic syncGate;
   logic syncMask;
   logic syncStrobe;
   dcpi_pkg::dcpiCmd_t syncCmd;
   assign syncP = pinSync_q[26];
   assign syncN = pinSync_q[25];
   assign syncGate = pinSync_q[24];
   assign syncCmd = pinSync_q[23:2];
   assign syncMask = pinSync_q[1];
   assign syncStrobe = pinSync_q[0];

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         clkPPrev_q <= 1'b0;
         clkNPrev_q <= 1'b1;
         strobePrev_q <= 1'b0;
      end else begin
         clkPPrev_q <= syncP;
         clkNPrev_q <= syncN;
         strobePrev_q <= syncStrobe;
      end
   end

   // true clock rising and complement falling together
   logic crossing;
   assign crossing = syncP && !syncN && !(clkPPrev_q && !clkNPrev_q);

   ////////////////////////////////////////////////////////////////////////////////
   // registers
   logic [31:0] ctrl_q;
   logic [13:0] modeReg_q [4];
   logic [15:0] maskedCount_q;
   logic [7:0] openBanks_q;
   logic gatePrev_q;
   dcpi_pkg::dcpiPwr_t pwr_q;

   logic decodeOn;
   logic emrTermOn;
   logic [3:0] burstBeats;
   assign decodeOn = ctrl_q[`DCPI_CTRL_DECODE_BIT];
   assign emrTermOn = modeReg_q[1][`DCPI_EMR_RTT_LO] || modeReg_q[1][`DCPI_EMR_RTT_HI];
   assign burstBeats = (modeReg_q[0][`DCPI_MR_BL_MSB:`DCPI_MR_BL_LSB] == `DCPI_MR_BL8) ?
                       `DCPI_BEATS_BL8 : `DCPI_BEATS_BL4;

   ////////////////////////////////////////////////////////////////////////////////
   // command decode
   logic [2:0] cmdCode;
   logic cmdLive;
   assign cmdCode = {syncCmd.rowStrobeN, syncCmd.columnStrobeN, syncCmd.writeStrobeN};
   // strobes decode only on a crossing with gate high now and before
   assign cmdLive = crossing && pwr_q == dcpi_pkg::PWR_RUN && gatePrev_q && syncGate &&
                    !syncCmd.rankSelectN && decodeOn;

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         cmdEvt <= '0;
      end else begin
         cmdEvt.activate <= cmdLive && cmdCode == `DCPI_CMD_ACTIVATE;
         cmdEvt.read <= cmdLive && cmdCode == `DCPI_CMD_READ;
         cmdEvt.write <= cmdLive && cmdCode == `DCPI_CMD_WRITE;
         cmdEvt.precharge <= cmdLive && cmdCode == `DCPI_CMD_PRECHARGE;
         cmdEvt.modeLoad <= cmdLive && cmdCode == `DCPI_CMD_MODE;
         cmdEvt.prechargeAll <= syncCmd.addr[`DCPI_PALL_BIT];
         cmdEvt.autoPrecharge <= syncCmd.addr[`DCPI_PALL_BIT];
         cmdEvt.bank <= syncCmd.bankSelect;
         cmdEvt.addr <= syncCmd.addr;
      end
   end

   // open row tracking per bank
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         openBanks_q <= '0;
      end else if (cmdLive) begin
         if (cmdCode == `DCPI_CMD_ACTIVATE) begin
            openBanks_q[syncCmd.bankSelect] <= 1'b1;
         end else if (cmdCode == `DCPI_CMD_PRECHARGE) begin
            if (syncCmd.addr[`DCPI_PALL_BIT]) begin
               openBanks_q <= '0;
            end else begin
               openBanks_q[syncCmd.bankSelect] <= 1'b0;
            end
         end else if ((cmdCode == `DCPI_CMD_READ || cmdCode == `DCPI_CMD_WRITE) &&
                      syncCmd.addr[`DCPI_PALL_BIT]) begin
            openBanks_q[syncCmd.bankSelect] <= 1'b0;
         end
      end
   end

   // mode register load, bank select picks the register
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         for (int i = 0; i < 4; i++) begin
            modeReg_q[i] <= '0;
         end
      end else if (cmdLive && cmdCode == `DCPI_CMD_MODE) begin
         modeReg_q[syncCmd.bankSelect[1:0]] <= syncCmd.addr;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // power states
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         gatePrev_q <= 1'b0;
      end else if (crossing && pwr_q != dcpi_pkg::PWR_SREF) begin
         gatePrev_q <= syncGate;
      end else if (pwr_q == dcpi_pkg::PWR_SREF) begin
         gatePrev_q <= 1'b0;
      end
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         pwr_q <= dcpi_pkg::PWR_RUN;
      end else begin
         case (pwr_q)
            dcpi_pkg::PWR_RUN: begin
               if (crossing && gatePrev_q && !syncGate) begin
                  if (!syncCmd.rankSelectN && cmdCode == `DCPI_CMD_REFRESH &&
                      openBanks_q == '0) begin
                     pwr_q <= dcpi_pkg::PWR_SREF;
                  end else if (openBanks_q != '0) begin
                     pwr_q <= dcpi_pkg::PWR_APD;
                  end else begin
                     pwr_q <= dcpi_pkg::PWR_PPD;
                  end
               end
            end
            dcpi_pkg::PWR_PPD, dcpi_pkg::PWR_APD: begin
               if (crossing && syncGate) begin
                  pwr_q <= dcpi_pkg::PWR_RUN;
               end
            end
            dcpi_pkg::PWR_SREF: begin
               if (syncGate) begin
                  pwr_q <= dcpi_pkg::PWR_RUN;
               end
            end
            default: begin
               pwr_q <= dcpi_pkg::PWR_RUN;
            end
         endcase
      end
   end

   // buffer enables follow the power state
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         pwrState <= dcpi_pkg::PWR_RUN;
         clockBufEn <= 1'b1;
         termBufEn <= 1'b1;
         inputBufEn <= 1'b1;
      end else begin
         pwrState <= pwr_q;
         inputBufEn <= pwr_q == dcpi_pkg::PWR_RUN;
         clockBufEn <= pwr_q != dcpi_pkg::PWR_SREF;
         termBufEn <= pwr_q != dcpi_pkg::PWR_SREF;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // termination and mask pin function
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         termOn <= 1'b0;
         termLanes <= '0;
         maskIsStrobe <= 1'b0;
      end else begin
         maskIsStrobe <= !WIDE16 && modeReg_q[1][`DCPI_EMR_READ_ONLY_STROBE];
         if (pwr_q == dcpi_pkg::PWR_SREF || !emrTermOn) begin
            termOn <= 1'b0;
            termLanes <= '0;
         end else if (crossing) begin
            termOn <= syncCmd.terminationEnable;
            termLanes <= {WIDE16 && syncCmd.terminationEnable, syncCmd.terminationEnable};
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // write beats on both strobe edges
   logic [3:0] beatsLeft_q;
   logic strobeEdge;
   logic beatIn;
   assign strobeEdge = syncStrobe != strobePrev_q;
   assign beatIn = strobeEdge && beatsLeft_q != '0;

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         beatsLeft_q <= '0;
      end else if (cmdLive && cmdCode == `DCPI_CMD_WRITE) begin
         beatsLeft_q <= burstBeats;
      end else if (beatIn) begin
         beatsLeft_q <= beatsLeft_q - 4'h1;
      end
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         beatKeep <= 1'b0;
         beatDrop <= 1'b0;
         maskedCount_q <= '0;
      end else begin
         beatKeep <= beatIn && (maskIsStrobe || !syncMask);
         beatDrop <= beatIn && !maskIsStrobe && syncMask;
         if (beatIn && !maskIsStrobe && syncMask) begin
            maskedCount_q <= maskedCount_q + 16'h1;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // axi4-lite write channel
   logic [11:0] awAddr_q;
   logic [31:0] wData_q;
   logic [3:0] wStrb_q;
   logic awHeld_q;
   logic wHeld_q;

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         awHeld_q <= 1'b0;
         wHeld_q <= 1'b0;
         awAddr_q <= '0;
         wData_q <= '0;
         wStrb_q <= '0;
         s_axi_awready <= 1'b1;
         s_axi_wready <= 1'b1;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= `DCPI_RESP_OKAY;
         ctrl_q <= `DCPI_CTRL_RESET;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            awAddr_q <= s_axi_awaddr;
            awHeld_q <= 1'b1;
            s_axi_awready <= 1'b0;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            wData_q <= s_axi_wdata;
            wStrb_q <= s_axi_wstrb;
            wHeld_q <= 1'b1;
            s_axi_wready <= 1'b0;
         end
         if (awHeld_q && wHeld_q && !s_axi_bvalid) begin
            awHeld_q <= 1'b0;
            wHeld_q <= 1'b0;
            s_axi_bvalid <= 1'b1;
            if (awAddr_q[11:2] == `DCPI_OFS_CTRL >> 2) begin
               s_axi_bresp <= `DCPI_RESP_OKAY;
               for (int b = 0; b < 4; b++) begin
                  if (wStrb_q[b]) begin
                     ctrl_q[b*8 +: 8] <= wData_q[b*8 +: 8];
                  end
               end
            end else if (awAddr_q[11:2] <= `DCPI_OFS_MASKED >> 2) begin
               s_axi_bresp <= `DCPI_RESP_OKAY;
            end else begin
               s_axi_bresp <= `DCPI_RESP_SLVERR;
            end
         end
         if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // axi4-lite read channel
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         s_axi_arready <= 1'b1;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= '0;
         s_axi_rresp <= `DCPI_RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b1;
         s_axi_rresp <= `DCPI_RESP_OKAY;
         if (s_axi_araddr[11:2] == `DCPI_OFS_STATUS >> 2) begin
            s_axi_rdata <= {20'h0, openBanks_q, pwr_q};
         end else if (s_axi_araddr[11:2] == `DCPI_OFS_CTRL >> 2) begin
            s_axi_rdata <= ctrl_q;
         end else if (s_axi_araddr[11:2] == `DCPI_OFS_MODE0 >> 2) begin
            s_axi_rdata <= {18'h0, modeReg_q[0]};
         end else if (s_axi_araddr[11:2] == `DCPI_OFS_MODE1 >> 2) begin
            s_axi_rdata <= {18'h0, modeReg_q[1]};
         end else if (s_axi_araddr[11:2] == `DCPI_OFS_MODE2 >> 2) begin
            s_axi_rdata <= {18'h0, modeReg_q[2]};
         end else if (s_axi_araddr[11:2] == `DCPI_OFS_MODE3 >> 2) begin
            s_axi_rdata <= {18'h0, modeReg_q[3]};
         end else if (s_axi_araddr[11:2] == `DCPI_OFS_MASKED >> 2) begin
            s_axi_rdata <= {16'h0, maskedCount_q};
         end else begin
            s_axi_rdata <= '0;
            s_axi_rresp <= `DCPI_RESP_SLVERR;
         end
      end else if (s_axi_rvalid && s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
         s_axi_arready <= 1'b1;
      end
   end

endmodule // dcpi_top
